// ### core/slrm_defs.vh
// register offsets, field positions and reset values of the link monitor
`ifndef SLRM_DEFS_VH
`define SLRM_DEFS_VH
// register indices (printed offsets, not multiples of four)
`define SLRM_IDX_LANE3_FLAGS 8'hE9
`define SLRM_IDX_UNEXP_FLAGS 8'hEA
`define SLRM_IDX_LOCK_01 8'hEB
`define SLRM_IDX_LOCK_23 8'hEC
`define SLRM_IDX_SYNC_STATE 8'hED
`define SLRM_IDX_FLAG_CTRL 8'hEE
`define SLRM_IDX_MISC_INT_EN 8'hEF
// status register of own choosing: alignment buffer errors
`define SLRM_IDX_BUF_ERR 8'hE3
// lane 3 flag field positions
`define SLRM_BIT_MF_LEN_ERR 7
`define SLRM_BIT_TOO_MANY_MF 6
`define SLRM_BIT_TOO_FEW_MF 5
// flag control field positions
`define SLRM_BIT_CLR_BUF_ERR 7
`define SLRM_BIT_AUTO_CLR_CNT 6
`define SLRM_BIT_FREEZE_CNT 5
// reset values
`define SLRM_RST_FLAG_CTRL 8'h00
`define SLRM_RST_MISC_INT_EN 8'h00
// code sync state value meaning initial state
`define SLRM_CS_INIT 2'h0
// multiframe count expected during alignment sequence
`define SLRM_ILA_MF_COUNT 3'h4
// axi response codes
`define SLRM_RESP_OKAY 2'h0
`define SLRM_RESP_SLVERR 2'h2
`endif

// ### core/slrm_ila_check.v
// per-lane alignment sequence multiframe checker with sticky error flags
`timescale 1ns/1ps
module slrm_ila_check (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // alignment sequence events
    input wire ilaStart,
    input wire ilaEnd,
    input wire mfEnd,
    input wire mfLenBad,
    // clear of the sticky flags
    input wire clear,
    // flags
    output reg mfLenErr,
    output reg tooMany,
    output reg tooFew
);
`include "slrm_defs.vh"
    reg [2:0] mfCount; // multiframes seen, saturating
    reg active; // inside alignment sequence
    // count multiframes and judge at sequence end; set wins over clear
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mfCount <= 3'h0;
            active <= 1'b0;
            mfLenErr <= 1'b0;
            tooMany <= 1'b0;
            tooFew <= 1'b0;
        end else begin
            if (ilaStart) begin
                active <= 1'b1;
                mfCount <= 3'h0;
            end else if (active && mfEnd && mfCount != 3'h7) begin
                mfCount <= mfCount + 3'h1;
            end
            if (active && ilaEnd) begin
                active <= 1'b0;
            end
            // irregular multiframe length
            if (active && mfEnd && mfLenBad) begin
                mfLenErr <= 1'b1; // [RULE1]
            end else if (clear) begin
                mfLenErr <= 1'b0;
            end
            // more than four multiframes
            if (active && ilaEnd && mfCount > `SLRM_ILA_MF_COUNT) begin
                tooMany <= 1'b1; // [RULE2]
            end else if (clear) begin
                tooMany <= 1'b0;
            end
            // fewer than four multiframes
            if (active && ilaEnd && mfCount < `SLRM_ILA_MF_COUNT) begin
                tooFew <= 1'b1; // [RULE3]
            end else if (clear) begin
                tooFew <= 1'b0;
            end
        end
    end
endmodule // slrm_ila_check

// ### core/slrm_lane_mon.v
// per-lane sticky control-character flags and lock state counter
`timescale 1ns/1ps
module slrm_lane_mon (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // decoder events, one-cycle pulses
    input wire [4:0] kSeen,
    input wire kUnexp,
    input wire lockLost,
    // counter and flag clear control
    input wire clrCnt,
    input wire freeze,
    input wire clrFlags,
    // results
    output reg [4:0] kFlags,
    output reg unexpFlag,
    output reg [3:0] lockCount
);
    // sticky flags; an event in the clearing cycle survives
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            kFlags <= 5'h00;
            unexpFlag <= 1'b0;
            lockCount <= 4'h0;
        end else begin
            kFlags <= (clrFlags ? 5'h00 : kFlags) | kSeen; // [RULE4]
            unexpFlag <= (unexpFlag & ~clrFlags) | kUnexp; // [RULE5]
            // lock state counter, saturating, clearable, freezable
            if (clrCnt) begin
                lockCount <= 4'h0; // [RULE9]
            end else if (lockLost && !freeze && lockCount != 4'hF) begin
                lockCount <= lockCount + 4'h1; // [RULE6]
            end
        end
    end
endmodule // slrm_lane_mon

// ### core/slrm_regs.v
// link receive monitor register bank with AXI4-Lite slave
// Contract
// [RULE1] lane 3 bit 7: irregular multiframe length
// [RULE2] lane 3 bit 6: more than four multiframes
// [RULE3] lane 3 bit 5: fewer than four multiframes
// [RULE4] lane 3 bits 4..0: F K Q A R seen
// [RULE5] unexpected control char flag, lane n bit n
// [RULE6] 4-bit lock counts, two lanes per byte
// [RULE7] 2-bit code sync state per lane packed
// [RULE8] control bit 7 clears buffer error flags
// [RULE9] bit 6 clears counters on link reset
// [RULE10] sync-init enables drive misc interrupt
// [RULE11] buffer error enables drive interrupt
// [RULE12] buffer error flag is pointer out of range
// [RULE13] interrupt is OR of enabled conditions
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module slrm_regs (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // axi4-lite write address
    input wire [9:0] awaddr,
    input wire awvalid,
    output wire awready,
    // axi4-lite write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // axi4-lite write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // axi4-lite read address
    input wire [9:0] araddr,
    input wire arvalid,
    output wire arready,
    // axi4-lite read data
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // per physical lane decoder events, five symbols per lane
    input wire [19:0] kSymbolSeen,
    input wire [3:0] kUnexpSeen,
    input wire [3:0] lockLost,
    input wire [7:0] codeSyncState,
    // lane 3 alignment sequence events
    input wire lane3IlaStart,
    input wire lane3IlaEnd,
    input wire lane3MfEnd,
    input wire lane3MfLenBad,
    // per logical lane buffer pointer out of range
    input wire [3:0] bufPtrOutOfRange,
    // reset of the data link processing block
    input wire linkReset,
    // miscellaneous interrupt
    output reg miscIrq
);
`include "slrm_defs.vh"
    // write channel holding registers
    reg awHeld; // write address captured
    reg wHeld; // write data captured
    reg [7:0] awIdx; // captured register index
    reg [7:0] wByte; // captured low byte
    reg wLane0; // low byte strobe
    // control registers
    reg [7:0] flagCtrl; // clear and counter control
    reg [7:0] miscIntEn; // interrupt enables
    // sticky buffer error flags
    reg [3:0] bufErr;
    // lane monitor outputs
    wire [19:0] kFlags;
    wire [3:0] unexpFlags;
    wire [15:0] lockCounts;
    // lane 3 alignment flags
    wire l3MfLen;
    wire l3TooMany;
    wire l3TooFew;
    // link reset synchronizer and edge
    reg linkRstMeta;
    reg linkRstSync;
    reg linkRstPrev;
    wire linkRstRise;
    // status input synchronizers
    reg [7:0] syncMeta;
    reg [7:0] syncState;
    reg [3:0] ptrMeta;
    reg [3:0] ptrSync;
    // read, write, clear and interrupt decode
    reg [7:0] rdByte;
    reg rdHit;
    wire [7:0] arIdx;
    wire doWrite;
    wire writeHit;
    wire clrBufReq;
    wire clrCntReq;
    wire [7:0] initHit;
    integer i;

    // bus handshakes: accept a channel while not holding one
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign arready = !rvalid;
    assign arIdx = araddr[9:2];
    // both halves present: commit the write
    assign doWrite = awHeld && wHeld && !bvalid;
    assign writeHit = awIdx == `SLRM_IDX_FLAG_CTRL ||
        awIdx == `SLRM_IDX_MISC_INT_EN;

    // two-flop synchronisers for signals from the link domain
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            linkRstMeta <= 1'b0;
            linkRstSync <= 1'b0;
            linkRstPrev <= 1'b0;
            syncMeta <= 8'h00;
            syncState <= 8'h00;
            ptrMeta <= 4'h0;
            ptrSync <= 4'h0;
        end else begin
            linkRstMeta <= linkReset;
            linkRstSync <= linkRstMeta;
            linkRstPrev <= linkRstSync;
            syncMeta <= codeSyncState;
            syncState <= syncMeta;
            ptrMeta <= bufPtrOutOfRange;
            ptrSync <= ptrMeta;
        end
    end
    assign linkRstRise = linkRstSync && !linkRstPrev;

    // clear counters on link reset only when auto clear is set
    assign clrCntReq = linkRstRise &&
        flagCtrl[`SLRM_BIT_AUTO_CLR_CNT]; // [RULE9]
    assign clrBufReq = flagCtrl[`SLRM_BIT_CLR_BUF_ERR]; // [RULE8]

    // per physical lane monitors
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gLane
            slrm_lane_mon uMon (
                .clk(clk),
                .arst_n(arst_n),
                .kSeen(kSymbolSeen[g*5 +: 5]),
                .kUnexp(kUnexpSeen[g]),
                .lockLost(lockLost[g]),
                .clrCnt(clrCntReq),
                .freeze(flagCtrl[`SLRM_BIT_FREEZE_CNT]),
                .clrFlags(clrCntReq),
                .kFlags(kFlags[g*5 +: 5]),
                .unexpFlag(unexpFlags[g]),
                .lockCount(lockCounts[g*4 +: 4])
            );
            assign initHit[g] = syncState[g*2 +: 2] == `SLRM_CS_INIT;
            assign initHit[g+4] = 1'b0;
        end
    endgenerate

    // lane 3 alignment sequence checker
    slrm_ila_check uIla (
        .clk(clk),
        .arst_n(arst_n),
        .ilaStart(lane3IlaStart),
        .ilaEnd(lane3IlaEnd),
        .mfEnd(lane3MfEnd),
        .mfLenBad(lane3MfLenBad),
        .clear(clrCntReq),
        .mfLenErr(l3MfLen),
        .tooMany(l3TooMany),
        .tooFew(l3TooFew)
    );

    // buffer error flags: out of range sets, clear bit resets
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bufErr <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (ptrSync[i]) begin
                    bufErr[i] <= 1'b1; // [RULE12]
                end else if (clrBufReq) begin
                    bufErr[i] <= 1'b0; // [RULE8]
                end
            end
        end
    end

    // miscellaneous interrupt from enabled conditions
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miscIrq <= 1'b0;
        end else begin
            miscIrq <= |(miscIntEn[7:4] & initHit[3:0]) | // [RULE10]
                |(miscIntEn[3:0] & bufErr); // [RULE11] [RULE13]
        end
    end

    // write path: capture address and data in either order
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awIdx <= 8'h00;
            wByte <= 8'h00;
            wLane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `SLRM_RESP_OKAY;
            flagCtrl <= `SLRM_RST_FLAG_CTRL;
            miscIntEn <= `SLRM_RST_MISC_INT_EN;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awIdx <= awaddr[9:2];
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wByte <= wdata[7:0];
                wLane0 <= wstrb[0];
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= writeHit ? `SLRM_RESP_OKAY : `SLRM_RESP_SLVERR;
                // register write, low byte lane only
                if (wLane0 && awIdx == `SLRM_IDX_FLAG_CTRL) begin
                    flagCtrl <= {wByte[7:5], 5'h00}; // [RULE8]
                end
                if (wLane0 && awIdx == `SLRM_IDX_MISC_INT_EN) begin
                    miscIntEn <= wByte; // [RULE10]
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read decode of the register map
    always @* begin
        rdByte = 8'h00;
        rdHit = 1'b1;
        case (arIdx)
            `SLRM_IDX_LANE3_FLAGS: begin
                rdByte = {l3MfLen, l3TooMany, l3TooFew,
                    kFlags[19:15]}; // [RULE1] [RULE2] [RULE3] [RULE4]
            end
            `SLRM_IDX_UNEXP_FLAGS: begin
                rdByte = {4'h0, unexpFlags}; // [RULE5]
            end
            `SLRM_IDX_LOCK_01: begin
                rdByte = lockCounts[7:0]; // [RULE6]
            end
            `SLRM_IDX_LOCK_23: begin
                rdByte = lockCounts[15:8]; // [RULE6]
            end
            `SLRM_IDX_SYNC_STATE: begin
                rdByte = syncState; // [RULE7]
            end
            `SLRM_IDX_FLAG_CTRL: begin
                rdByte = flagCtrl;
            end
            `SLRM_IDX_MISC_INT_EN: begin
                rdByte = miscIntEn;
            end
            `SLRM_IDX_BUF_ERR: begin
                rdByte = {4'h0, bufErr}; // [RULE12]
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // read path: answer one cycle after the address is taken
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `SLRM_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rdByte};
                rresp <= rdHit ? `SLRM_RESP_OKAY : `SLRM_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // slrm_regs

// ### bench/slrm_asserts.sv
// checker of the link monitor register bank, seen from its ports
`timescale 1ns/1ps
`include "slrm_defs.vh"
module slrm_asserts (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // write channels
    input wire [9:0] awaddr,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    // read channels
    input wire [9:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    input wire rready,
    // lane status and interrupt
    input wire [7:0] codeSyncState,
    input wire [3:0] bufPtrOutOfRange,
    input wire miscIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire arHs = arvalid && arready; // read address taken
    wire wHs = awvalid && awready && wvalid && wready; // write taken
    wire [7:0] arIdx = araddr[9:2];
    wire [7:0] awIdx = awaddr[9:2];
    // mapped: own buffer error register plus the documented window
    wire mapped = arIdx == `SLRM_IDX_BUF_ERR ||
        (arIdx >= `SLRM_IDX_LANE3_FLAGS && arIdx <= `SLRM_IDX_MISC_INT_EN);
    reg [11:0] prevIn; // last lane levels
    reg [3:0] stab; // cycles the lane levels stayed put
    // counts how long the asynchronous levels have been stable
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevIn <= 12'h000;
            stab <= 4'h0;
        end else begin
            prevIn <= {codeSyncState, bufPtrOutOfRange};
            if (prevIn != {codeSyncState, bufPtrOutOfRange})
                stab <= 4'h0;
            else if (stab != 4'hF)
                stab <= stab + 4'h1;
        end
    end
    property p_rd_lat; arHs |=> rvalid; endproperty
    property p_rd_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    property p_wr_lat; wHs |-> ##2 bvalid; endproperty
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_unmap;
        arHs && !mapped |=> rresp == `SLRM_RESP_SLVERR && rdata == 32'h0;
    endproperty
    property p_ro_wr;
        wHs && awIdx >= `SLRM_IDX_LANE3_FLAGS && awIdx <= `SLRM_IDX_SYNC_STATE
        |-> ##2 bresp == `SLRM_RESP_SLVERR;
    endproperty
    property p_hi_zero; rvalid |-> rdata[31:8] == 24'h0; endproperty
    property p_sync;
        arHs && arIdx == `SLRM_IDX_SYNC_STATE && stab >= 4'h6
        |=> rdata[7:0] == $past(codeSyncState);
    endproperty
    property p_buf;
        arHs && arIdx == `SLRM_IDX_BUF_ERR && stab >= 4'h6
        |=> (rdata[3:0] & $past(bufPtrOutOfRange)) == $past(bufPtrOutOfRange);
    endproperty
    property p_irq_rst; $rose(arst_n) |-> !miscIrq [*2]; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    a_b_hold: assert property (p_b_hold) else $error("write resp moved");
    a_unmap: assert property (p_unmap) else $error("unmapped read ok");
    a_ro_wr: assert property (p_ro_wr) else $error("ro write ok");
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits");
    a_sync: assert property (p_sync) else $error("sync state");
    a_buf: assert property (p_buf) else $error("buffer flag");
    a_irq_rst: assert property (p_irq_rst) else $error("irq");
    c_sync: cover property (arHs && arIdx == `SLRM_IDX_SYNC_STATE);
    c_irq: cover property ($rose(miscIrq));
    c_err: cover property (bvalid && bresp == `SLRM_RESP_SLVERR);
endmodule // slrm_asserts
bind slrm_regs slrm_asserts u_chk (.clk(clk), .arst_n(arst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .codeSyncState(codeSyncState),
    .bufPtrOutOfRange(bufPtrOutOfRange), .miscIrq(miscIrq));

// ### bench/slrm_link_tx.sv
// link transmitter model: decoder events and lane status levels
`timescale 1ns/1ps
module slrm_link_tx (
    // clock
    input wire clk,
    // decoder events, one-cycle pulses
    output reg [19:0] kSymbolSeen,
    output reg [3:0] kUnexpSeen,
    output reg [3:0] lockLost,
    // lane 3 alignment events
    output reg ilaStart,
    output reg ilaEnd,
    output reg mfEnd,
    output reg mfLenBad,
    // status levels
    output reg [7:0] codeSyncState,
    output reg [3:0] bufPtrOutOfRange,
    output reg linkReset
);
    // idle: no events, every lane past its initial sync state
    initial begin
        {kSymbolSeen, kUnexpSeen, lockLost} = 28'h0;
        {ilaStart, ilaEnd, mfEnd, mfLenBad, linkReset} = 5'h0;
        codeSyncState = 8'hFF;
        bufPtrOutOfRange = 4'h0;
    end
    // one cycle of decoder events
    task evt(input [19:0] k, input [3:0] u, input [3:0] l);
        begin
            @(posedge clk);
            {kSymbolSeen, kUnexpSeen, lockLost} <= {k, u, l};
            @(posedge clk);
            {kSymbolSeen, kUnexpSeen, lockLost} <= 28'h0;
        end
    endtask
    // alignment sequence of n multiframes, optionally of bad length
    task ila(input integer n, input bad);
        integer i;
        begin
            @(posedge clk);
            ilaStart <= 1'h1;
            @(posedge clk);
            ilaStart <= 1'h0;
            for (i = 0; i < n; i = i + 1) begin
                mfEnd <= 1'h1;
                mfLenBad <= bad;
                @(posedge clk);
                {mfEnd, mfLenBad} <= 2'h0;
                @(posedge clk);
            end
            ilaEnd <= 1'h1;
            @(posedge clk);
            ilaEnd <= 1'h0;
        end
    endtask
    // new lane status levels
    task levels(input [7:0] cs, input [3:0] p);
        begin
            @(posedge clk);
            codeSyncState <= cs;
            bufPtrOutOfRange <= p;
        end
    endtask
    // reset of the data link processing block, held a few cycles
    task linkRst;
        begin
            @(posedge clk);
            linkReset <= 1'h1;
            repeat (4) @(posedge clk);
            linkReset <= 1'h0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule // slrm_link_tx

// ### bench/tb_slrm_regs.sv
// testbench of the link monitor register bank
`timescale 1ns/1ps
module tb_slrm_regs;
    reg clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
    reg [9:0] awaddr, araddr;
    reg [31:0] wdata;
    reg [3:0] wstrb;
    reg [1:0] lastResp; // response of the last access
    integer bad_count, tests_run;
    wire awready, wready, bvalid, arready, rvalid, miscIrq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [19:0] kSym;
    wire [3:0] kUnexp, lockLost, bufPtr;
    wire [7:0] csState;
    wire ilaStart, ilaEnd, mfEnd, mfLenBad, linkReset;
    slrm_link_tx tx (.clk(clk), .kSymbolSeen(kSym), .kUnexpSeen(kUnexp),
        .lockLost(lockLost), .ilaStart(ilaStart), .ilaEnd(ilaEnd),
        .mfEnd(mfEnd), .mfLenBad(mfLenBad), .codeSyncState(csState),
        .bufPtrOutOfRange(bufPtr), .linkReset(linkReset));
    slrm_regs dut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .kSymbolSeen(kSym), .kUnexpSeen(kUnexp),
        .lockLost(lockLost), .codeSyncState(csState),
        .lane3IlaStart(ilaStart), .lane3IlaEnd(ilaEnd),
        .lane3MfEnd(mfEnd), .lane3MfLenBad(mfLenBad),
        .bufPtrOutOfRange(bufPtr), .linkReset(linkReset),
        .miscIrq(miscIrq));
    // 40 MHz clock
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // axi4-lite write of one register byte
    task wr(input [7:0] idx, input [7:0] d);
        integer n;
        begin
            @(posedge clk);
            awaddr <= {idx, 2'h0};
            wdata <= {24'h0, d};
            {awvalid, wvalid, bready} <= 3'h7;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
            end while (bvalid !== 1'h1 && n < 40);
            lastResp = bresp;
            bready <= 1'h0;
        end
    endtask
    // axi4-lite read of one register, compared with exp
    task rd(input [7:0] idx, input [7:0] exp);
        integer n;
        begin
            @(posedge clk);
            araddr <= {idx, 2'h0};
            {arvalid, rready} <= 2'h3;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
                if (arready) arvalid <= 1'h0;
            end while (rvalid !== 1'h1 && n < 40);
            lastResp = rresp;
            chk(rdata, {24'h0, exp});
            rready <= 1'h0;
        end
    endtask
    // verdict and end of run
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    // main sequence
    initial begin : seq
        integer i;
        {bad_count, tests_run} = 64'h0;
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 56'h000000000000F;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        rd(8'hEE, 8'h00);
        rd(8'hEF, 8'h00);
        rd(8'h00, 8'h00);
        chk(lastResp, 32'h2);
        wr(8'hE9, 8'hFF);
        chk(lastResp, 32'h2);
        wr(8'hEF, 8'hFF);
        rd(8'hEF, 8'hFF);
        wr(8'hEF, 8'h00);
        $display("test access ended");
        for (i = 0; i < 5; i = i + 1) begin
            tx.evt(20'h08000 << i, 4'h0, 4'h0);
            rd(8'hE9, (8'h02 << i) - 8'h01);
        end
        tx.ila(4, 1'h0);
        rd(8'hE9, 8'h1F);
        tx.ila(5, 1'h0);
        rd(8'hE9, 8'h5F);
        wr(8'hEE, 8'h40);
        tx.linkRst;
        rd(8'hE9, 8'h00);
        tx.ila(3, 1'h0);
        rd(8'hE9, 8'h20);
        tx.ila(4, 1'h1);
        rd(8'hE9, 8'hA0);
        $display("test lane 3 flags ended");
        tx.evt(20'h0, 4'h5, 4'hF);
        tx.evt(20'h0, 4'h0, 4'hE);
        tx.evt(20'h0, 4'h0, 4'hC);
        tx.evt(20'h0, 4'h0, 4'h8);
        rd(8'hEA, 8'h05);
        rd(8'hEB, 8'h21);
        rd(8'hEC, 8'h43);
        $display("test counters ended");
        tx.levels(8'hE4, 4'h0);
        repeat (8) @(posedge clk);
        rd(8'hED, 8'hE4);
        chk(miscIrq, 32'h0);
        wr(8'hEF, 8'h10);
        repeat (6) @(posedge clk);
        chk(miscIrq, 32'h1);
        wr(8'hEF, 8'h20);
        repeat (6) @(posedge clk);
        chk(miscIrq, 32'h0);
        tx.levels(8'hFF, 4'h2);
        repeat (8) @(posedge clk);
        tx.levels(8'hFF, 4'h0);
        rd(8'hE3, 8'h02);
        wr(8'hEF, 8'h02);
        repeat (6) @(posedge clk);
        chk(miscIrq, 32'h1);
        wr(8'hEE, 8'h80);
        wr(8'hEE, 8'h00);
        rd(8'hE3, 8'h00);
        repeat (6) @(posedge clk);
        chk(miscIrq, 32'h0);
        $display("test interrupt ended");
        tally_and_finish;
    end
endmodule // tb_slrm_regs
